// File: core/sac_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts for the converter control block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   All constants are macros.
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// Register byte offsets
`define SAC_OFF_CTRL0      12'h000
`define SAC_OFF_PINREF     12'h004
`define SAC_OFF_TIMING     12'h008
`define SAC_OFF_RES_HIGH   12'h00C
`define SAC_OFF_RES_LOW    12'h010
`define SAC_OFF_FLAGS      12'h014
`define SAC_OFF_PORTIN     12'h018

// Control register 0 fields
`define SAC_CTRL0_EN_BIT   0
`define SAC_CTRL0_GO_BIT   1
`define SAC_CTRL0_CHS_LO   2
`define SAC_CTRL0_CHS_HI   5
`define SAC_CTRL0_RESET    8'h00

// Pin and reference config fields
`define SAC_PINREF_REF_BIT 4
`define SAC_PINREF_RESET   8'h00

// Timing config fields
`define SAC_TIM_CLK_LO     0
`define SAC_TIM_CLK_HI     2
`define SAC_TIM_ACQ_LO     3
`define SAC_TIM_ACQ_HI     5
`define SAC_TIM_RC_CODE    3'h7
`define SAC_TIM_RESET      8'h00

// Flag register fields
`define SAC_FLAG_DONE_BIT  0
`define SAC_FLAG_IE_BIT    1

// Channel codes
`define SAC_CHS_LAST       4'hC
`define SAC_CHS_SMALL_LO   4'h5
`define SAC_CHS_SMALL_HI   4'h7

// Timing
`define SAC_RC_PERIOD_NS   1000
`define SAC_CLK_NS         10
`define SAC_RC_DIV         (`SAC_RC_PERIOD_NS / `SAC_CLK_NS)
`define SAC_GAP_TAD        2
`define SAC_INSTR_CYC      4
`define SAC_RES_BITS       12

`endif

// File: core/sac_tad_div.v
// Purpose: Conversion bit period enable generator.
// Assumes: Single clock pclk; divide selection held stable while running.
// Notes:   Emits one-cycle pulse per bit period; counter restarts on clear.
`include "sac_map.vh"

module sac_tad_div (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clr,
  input  wire [2:0]  sel,
  output reg         tad_pulse
);

  reg  [7:0]  cnt_q;
  wire [7:0]  limit;
  wire [31:0] rc_limit;

  // RC period is an integer macro; cut to the counter width on purpose
  assign rc_limit = `SAC_RC_DIV - 1;
  // RC code uses internal period, others use 2^(sel+1) clocks
  assign limit = (sel == `SAC_TIM_RC_CODE) ? rc_limit[7:0] : ((8'h02 << sel) - 8'h01);

  // Free counter gated by clear so each phase starts a whole period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q     <= 8'h00;
      tad_pulse <= 1'b0;
    end
    else if (clr)
    begin
      cnt_q     <= 8'h00;
      tad_pulse <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q     <= 8'h00;
      tad_pulse <= 1'b1;
    end
    else
    begin
      cnt_q     <= cnt_q + 8'h01;
      tad_pulse <= 1'b0;
    end
  end

endmodule // sac_tad_div

// File: core/sac_ctrl.v
// Purpose: Control for a 12-bit successive-approximation converter behind APB.
// Assumes: Analog mux, sample-and-hold and comparator sit outside; comparator is a pin.
// Notes:   Result registers are not reset by presetn, only by por_n.
// Function
// - Ten or thirteen inputs, 12-bit result
// - Channel field bits 5..2, codes 0..12
// - Small package lacks codes 5 to 7
// - Unimplemented channel still converts, floating value
// - Bit 1 is start and busy
// - Bit 0 enables the converter
// - Bits 7..6 read zero; reset zero
// - Reference: supply rails or external pins
// - Result by successive approximation from hold
// - Sleep conversion only with RC clock
// - Reset clears registers, aborts conversion
// - Completion loads result, clears busy, sets flag
// - Result kept except power-on reset
// - Programmable acquisition delay before conversion
// - Two bit periods before next acquisition
// - Zero acquisition delays one instruction cycle
// - Analog pins read zero on port
// - Result valid the cycle after completion
//
// Added by the designer: the register offsets and the APB slave port.
`include "sac_map.vh"

module sac_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        por_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        large_pkg,
  input  wire        sleep_mode,
  input  wire        cmp_in,
  input  wire [12:0] pin_level,
  output reg  [3:0]  mux_sel,
  output reg         mux_valid,
  output reg         ref_external,
  output reg         sample_hold,
  output reg  [11:0] dac_code,
  output reg         conv_busy,
  output wire        irq
);

  localparam ST_IDLE = 3'd0;
  localparam ST_DLY  = 3'd1;
  localparam ST_ACQ  = 3'd2;
  localparam ST_CONV = 3'd3;
  localparam ST_GAP  = 3'd4;

  reg  [2:0]  state_q;
  reg  [3:0]  chs_q;
  reg         en_q;
  reg         go_q;
  reg  [7:0]  pinref_q;
  reg  [7:0]  timing_q;
  reg         done_q;
  reg         ie_q;
  reg  [11:0] result_q;
  reg  [11:0] sar_q;
  reg  [3:0]  bit_q;
  reg  [4:0]  cnt_q;
  reg  [2:0]  dly_q;
  reg  [12:0] cmp_s1_q;
  reg  [12:0] cmp_s2_q;
  reg  [12:0] cmp_s3_q;
  reg  [12:0] pin_q;
  reg         c1_q;
  reg         c2_q;
  reg         c3_q;
  reg         cmp_q;
  wire        wr_en;
  wire        rd_en;
  wire        tad;
  wire        tad_clr;
  wire        go_set;
  wire        complete;
  wire [2:0]  acq_sel;
  wire [4:0]  acq_tads;
  wire        chan_impl;
  wire        rc_clk;
  wire [12:0] analog_mask;
  integer     i;

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign acq_sel  = timing_q[`SAC_TIM_ACQ_HI:`SAC_TIM_ACQ_LO];
  assign rc_clk   = (timing_q[`SAC_TIM_CLK_HI:`SAC_TIM_CLK_LO] == `SAC_TIM_RC_CODE);
  // Acquisition length in bit periods: 0,2,4,6,8,12,16,20; twenty needs five bits
  assign acq_tads = (acq_sel < 3'd5) ? {1'b0, acq_sel, 1'b0} : {acq_sel - 3'd2, 2'b00};
  // Start only while enabled; a write of go with enable off is dropped
  assign go_set   = wr_en & (paddr == `SAC_OFF_CTRL0) & pwdata[`SAC_CTRL0_GO_BIT]
                    & pwdata[`SAC_CTRL0_EN_BIT] & (state_q == ST_IDLE);
  // Clock stops in sleep unless the RC source runs the converter
  assign tad_clr  = (state_q == ST_IDLE) | (state_q == ST_DLY) | (sleep_mode & ~rc_clk);
  assign complete = (state_q == ST_CONV) & tad & (bit_q == 4'd0);
  assign irq      = done_q & ie_q;

  // Codes above twelve, and five to seven on the small package, have no pin
  assign chan_impl = (chs_q <= `SAC_CHS_LAST) &
                     (large_pkg | (chs_q < `SAC_CHS_SMALL_LO) | (chs_q > `SAC_CHS_SMALL_HI));

  // Pins 0..(N-1) analog by config count in pinref low nibble
  genvar g;
  generate
    for (g = 0; g < 13; g = g + 1)
    begin : g_amask
      assign analog_mask[g] = (g < pinref_q[3:0]);
    end
  endgenerate

  sac_tad_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (tad_clr),
    .sel       (timing_q[`SAC_TIM_CLK_HI:`SAC_TIM_CLK_LO]),
    .tad_pulse (tad)
  );

  // Comparator and port pins come from the analog side: three-stage sync
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1_q     <= 1'b0;
      c2_q     <= 1'b0;
      c3_q     <= 1'b0;
      cmp_q    <= 1'b0;
      cmp_s1_q <= 13'h0000;
      cmp_s2_q <= 13'h0000;
      cmp_s3_q <= 13'h0000;
      pin_q    <= 13'h0000;
    end
    else
    begin
      c1_q     <= cmp_in;
      c2_q     <= c1_q;
      c3_q     <= c2_q;
      cmp_s1_q <= pin_level;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      if (c2_q == c3_q)
        cmp_q <= c2_q;
      for (i = 0; i < 13; i = i + 1)
        if (cmp_s2_q[i] == cmp_s3_q[i])
          pin_q[i] <= cmp_s2_q[i];
    end
  end

  // Register writes and sequencer share one process so go and busy stay coherent
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= ST_IDLE;
      chs_q    <= 4'h0;
      en_q     <= 1'b0;
      go_q     <= 1'b0;
      pinref_q <= `SAC_PINREF_RESET;
      timing_q <= `SAC_TIM_RESET;
      done_q   <= 1'b0;
      ie_q     <= 1'b0;
      sar_q    <= 12'h000;
      bit_q    <= 4'h0;
      cnt_q    <= 5'h00;
      dly_q    <= 3'd0;
    end
    else
    begin
      if (wr_en)
      begin
        case (paddr)
          `SAC_OFF_CTRL0:
          begin
            en_q  <= pwdata[`SAC_CTRL0_EN_BIT];
            chs_q <= pwdata[`SAC_CTRL0_CHS_HI:`SAC_CTRL0_CHS_LO];
          end
          `SAC_OFF_PINREF: pinref_q <= pwdata[7:0];
          `SAC_OFF_TIMING: timing_q <= pwdata[7:0];
          `SAC_OFF_FLAGS:
          begin
            ie_q <= pwdata[`SAC_FLAG_IE_BIT];
            if (!pwdata[`SAC_FLAG_DONE_BIT])
              done_q <= 1'b0;
          end
          default: ;
        endcase
      end
      // Completion set wins over a same-cycle software clear
      if (complete)
        done_q <= 1'b1;
      case (state_q)
        ST_IDLE:
        begin
          if (go_set)
          begin
            go_q  <= 1'b1;
            dly_q <= 3'd0;
            cnt_q <= 5'h00;
            state_q <= (acq_sel == 3'd0) ? ST_DLY : ST_ACQ;
          end
        end
        ST_DLY:
        begin
          // Hold off one instruction cycle so a sleep can be entered first
          dly_q <= dly_q + 3'd1;
          if (dly_q == `SAC_INSTR_CYC - 1)
          begin
            state_q <= ST_CONV;
            bit_q   <= 4'd11;
            sar_q   <= 12'h800;
          end
        end
        ST_ACQ:
        begin
          if (tad)
          begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q + 5'h01 >= acq_tads)
            begin
              state_q <= ST_CONV;
              bit_q   <= 4'd11;
              sar_q   <= 12'h800;
            end
          end
        end
        ST_CONV:
        begin
          // One trial bit per bit period, MSB first; keep bit if input above trial
          if (tad)
          begin
            if (!cmp_q)
              sar_q[bit_q] <= 1'b0;
            if (bit_q != 4'd0)
            begin
              sar_q[bit_q - 4'd1] <= 1'b1;
              bit_q <= bit_q - 4'd1;
            end
            else
            begin
              go_q    <= 1'b0;
              cnt_q   <= 5'h00;
              state_q <= ST_GAP;
            end
          end
        end
        ST_GAP:
        begin
          if (tad)
          begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q + 5'h01 >= `SAC_GAP_TAD)
              state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Turning the module off aborts any conversion
      if (wr_en && (paddr == `SAC_OFF_CTRL0) && !pwdata[`SAC_CTRL0_EN_BIT])
      begin
        state_q <= ST_IDLE;
        go_q    <= 1'b0;
      end
    end
  end

  // Result survives presetn; only power-on reset touches it
  always @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      result_q <= 12'h000;
    else if (complete)
      result_q <= {sar_q[11:1], sar_q[0] & cmp_q};
  end

  // Analog-side drive registered from state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_sel      <= 4'h0;
      mux_valid    <= 1'b0;
      ref_external <= 1'b0;
      sample_hold  <= 1'b0;
      dac_code     <= 12'h000;
      conv_busy    <= 1'b0;
    end
    else
    begin
      mux_sel      <= chs_q;
      mux_valid    <= en_q & chan_impl;
      ref_external <= pinref_q[`SAC_PINREF_REF_BIT];
      sample_hold  <= (state_q == ST_CONV) | (state_q == ST_DLY);
      dac_code     <= sar_q;
      conv_busy    <= go_q;
    end
  end

  // Read mux; unmapped offsets read zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        `SAC_OFF_CTRL0:    prdata <= {24'h000000, 2'b00, chs_q, go_q, en_q};
        `SAC_OFF_PINREF:   prdata <= {24'h000000, pinref_q};
        `SAC_OFF_TIMING:   prdata <= {24'h000000, timing_q};
        `SAC_OFF_RES_HIGH: prdata <= {28'h0000000, result_q[11:8]};
        `SAC_OFF_RES_LOW:  prdata <= {24'h000000, result_q[7:0]};
        `SAC_OFF_FLAGS:    prdata <= {30'h00000000, ie_q, done_q};
        `SAC_OFF_PORTIN:   prdata <= {19'h00000, pin_q & ~analog_mask};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // sac_ctrl

// File: testbench/sac_afe_model.sv
// Purpose: Far-side analog front end: channel mux, sample-and-hold, comparator.
// Assumes: Channel n carries the level n*300+7; an open input settles at FLOAT_CODE.
// Notes:   The comparator answers at once; the block's synchroniser adds the delay.
module sac_afe_model #(
  parameter logic [11:0] FLOAT_CODE = 12'hA5C
) (
  input  wire logic [3:0]  mux_sel,
  input  wire logic        mux_valid,
  input  wire logic        sample_hold,
  input  wire logic [11:0] dac_code,
  output wire logic        cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] live;
  logic [11:0] held;

  // An input that is not wired floats to a fixed level, no error code
  assign live = mux_valid ? 12'(mux_sel * 300 + 7) : FLOAT_CODE;

  // Track while sampling and freeze once the hold starts
  always @(live or sample_hold)
    if (!sample_hold)
      held = live;

  // Equal counts as above so the search lands on the exact level
  assign cmp_in = (held >= dac_code);
endmodule // sac_afe_model

// File: testbench/sac_props.sv
// Purpose: Port-level checks on the converter control block.
// Assumes: One clock; presetn asynchronous, active low.
// Notes:   Bit period is at least 2 clocks, so the gap is at least 4.
module sac_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        large_pkg,
  input wire logic [3:0]  mux_sel,
  input wire logic        mux_valid,
  input wire logic        ref_external,
  input wire logic        sample_hold,
  input wire logic [11:0] dac_code,
  input wire logic        conv_busy,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr    = psel && penable && pwrite;
  wire go_wr = wr && paddr == 12'h000 && pwdata[1:0] == 2'b11;

  property p_rdy; pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer not zero wait");
  property p_start; $rose(conv_busy) |-> $past(go_wr) || $past(go_wr, 2) || $past(go_wr, 3); endproperty
  a_start: assert property (p_start) else $error("busy rose without enabled start");
  property p_irq; $rose(irq) |-> $past(conv_busy) || $past(conv_busy, 2) || $past(wr); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without completion");
  property p_sh; sample_hold |-> conv_busy || $past(conv_busy); endproperty
  a_sh: assert property (p_sh) else $error("hold outside conversion");
  property p_mux;
    mux_valid && $stable(large_pkg) |-> mux_sel <= 4'hC && (large_pkg || mux_sel < 4'h5 || mux_sel > 4'h7);
  endproperty
  a_mux: assert property (p_mux) else $error("unimplemented channel marked valid");
  // Register then output flop: the write lies two samples back
  property p_ref; $changed(ref_external) |-> $past(wr && paddr == 12'h004, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference changed without write");
  property p_dac; $changed(dac_code) |-> conv_busy || $past(conv_busy); endproperty
  a_dac: assert property (p_dac) else $error("trial code moved while idle");
  property p_rel; $rose(presetn) |-> !conv_busy && !sample_hold && !irq; endproperty
  a_rel: assert property (p_rel) else $error("activity right after reset");
  property p_gap; $fell(conv_busy) |-> !conv_busy [*4]; endproperty
  a_gap: assert property (p_gap) else $error("restart inside gap");

  c_done: cover property ($fell(conv_busy) && irq);
  c_small: cover property (!large_pkg && conv_busy);
  c_abort: cover property ($fell(conv_busy) && !irq);
endmodule // sac_props

bind sac_ctrl sac_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .large_pkg, .mux_sel, .mux_valid, .ref_external, .sample_hold, .dac_code, .conv_busy, .irq);

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the converter control block over APB.
// Assumes: Zero-wait slave; bit period 8 clocks unless the RC code is chosen.
// Notes:   Interrupt enable is kept set so every completion shows on irq.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] FLOAT_CODE = 12'hA5C;
  logic        pclk, presetn, por_n, psel, penable, pwrite, large_pkg, sleep_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [12:0] pin_level;
  wire         pready, pslverr, mux_valid, ref_external, sample_hold, conv_busy, irq, cmp_in;
  wire  [31:0] prdata;
  wire  [3:0]  mux_sel;
  wire  [11:0] dac_code;
  int          fails, checks_done, busy_cyc;

  sac_ctrl i_dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .large_pkg, .sleep_mode, .cmp_in, .pin_level, .mux_sel, .mux_valid, .ref_external,
    .sample_hold, .dac_code, .conv_busy, .irq);
  sac_afe_model #(.FLOAT_CODE(FLOAT_CODE)) i_afe (.mux_sel, .mux_valid, .sample_hold, .dac_code, .cmp_in);

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Busy length counter, sampled only by differences
  always @(posedge pclk)
    if (conv_busy === 1'b1)
      busy_cyc <= busy_cyc + 1;

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      fails++;
      tally_and_finish;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Poll the busy bit with a bound
  task wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[1] === 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      fails++;
      tally_and_finish;
    end
  endtask

  task start(input logic [3:0] c, input logic [2:0] acq, input logic [2:0] sel);
    apb(1'b1, 12'h008, {26'h0, acq, sel});
    apb(1'b1, 12'h000, {26'h0, c, 2'b01});
    apb(1'b1, 12'h000, {26'h0, c, 2'b11});
  endtask

  // Full conversion with timing, result, flag and irq checks
  task convert(input logic [3:0] c, input logic [2:0] acq, input logic [2:0] sel);
    int tclk, ecyc, b0, d;
    logic impl;
    logic [11:0] ev;
    tclk = (sel == 3'h7) ? 100 : (2 << sel);
    // Acquisition 0,2,4,6,8,12,16,20 bit periods; code zero waits one instruction cycle
    ecyc = 12 * tclk + ((acq == 3'h0) ? 4 : ((acq < 3'h5) ? 2 * acq : 4 * acq - 8) * tclk);
    impl = (c <= 4'hC) && (large_pkg || c < 4'h5 || c > 4'h7);
    ev = impl ? 12'(c * 300 + 7) : FLOAT_CODE;
    start(c, acq, sel);
    b0 = busy_cyc;
    wait_idle;
    d = busy_cyc - b0;
    chk(32'(d >= ecyc - tclk && d <= ecyc + 2 * tclk), 32'h1);
    chk(mux_valid, impl);
    rchk(12'h00C, {28'h0, ev[11:8]});
    rchk(12'h010, {24'h0, ev[7:0]});
    rchk(12'h014, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, 12'h014, 32'h2);
    rchk(12'h014, 32'h2);
    chk(irq, 1'b0);
    repeat (2 * tclk) @(posedge pclk);
  endtask

  task t_regs;
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    rchk(12'h008, 32'h0);
    rchk(12'h014, 32'h0);
    apb(1'b1, 12'h020, 32'hFF);
    rchk(12'h020, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    rchk(12'h014, 32'h0);
    apb(1'b1, 12'h000, 32'hF6);
    rchk(12'h000, 32'h34);
    chk(conv_busy, 1'b0);
    $display("t_regs done");
  endtask

  task t_chans;
    apb(1'b1, 12'h014, 32'h2);
    for (int c = 0; c < 16; c++)
      convert(c[3:0], c[2:0], 3'h2);
    large_pkg <= 1'b0;
    for (int c = 4; c < 9; c++)
      convert(c[3:0], 3'h1, 3'h2);
    large_pkg <= 1'b1;
    $display("t_chans done");
  endtask

  task t_sleep;
    sleep_mode <= 1'b1;
    start(4'h3, 3'h1, 3'h2);
    repeat (300) @(posedge pclk);
    chk(conv_busy, 1'b1);
    sleep_mode <= 1'b0;
    wait_idle;
    rchk(12'h010, 32'h8B);
    repeat (16) @(posedge pclk);
    apb(1'b1, 12'h014, 32'h2);
    sleep_mode <= 1'b1;
    convert(4'h6, 3'h0, 3'h7);
    sleep_mode <= 1'b0;
    $display("t_sleep done");
  endtask

  // Abort by disable, then by reset in mid-run; result must survive both
  task t_abort;
    convert(4'h1, 3'h0, 3'h2);
    start(4'h2, 3'h7, 3'h2);
    repeat (50) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h08);
    repeat (2) @(posedge pclk);
    chk(conv_busy, 1'b0);
    rchk(12'h014, 32'h2);
    rchk(12'h010, 32'h33);
    repeat (16) @(posedge pclk);
    start(4'h2, 3'h7, 3'h2);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(conv_busy, 1'b0);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0);
    rchk(12'h00C, 32'h1);
    rchk(12'h010, 32'h33);
    $display("t_abort done");
  endtask

  task t_ports;
    apb(1'b1, 12'h004, 32'h0);
    rchk(12'h018, 32'h1ACD);
    // Four analog pins: the low four port bits must read zero
    apb(1'b1, 12'h004, 32'h14);
    rchk(12'h018, 32'h1AC0);
    apb(1'b1, 12'h004, 32'h1D);
    rchk(12'h018, 32'h0);
    chk(ref_external, 1'b1);
    $display("t_ports done");
  endtask

  initial
  begin
    {presetn, por_n, psel, penable, pwrite, sleep_mode} = 6'h0;
    large_pkg = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_level = 13'h1ACD;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_regs;
    t_chans;
    t_sleep;
    t_abort;
    t_ports;
    tally_and_finish;
  end
endmodule // testbench
